/* File: design/itc_match_chan.sv */
/*
  one compare channel: equality against the counter on a timer tick,
  plus the forced-compare strobe with its sampled action.
  assumes tick, block and force come from logic on the same clock.
*/
`timescale 1ns/1ps
module itc_match_chan
  import itc_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick,
  input wire logic block,
  input wire logic forceReq,
  input wire logic [W-1:0] countVal,
  input wire logic [W-1:0] matchVal,
  input wire logic [1:0] action,
  output logic matchEvt,
  output logic forceEvt,
  output logic [1:0] forceAct
);
  logic hit;
  logic matchEvt_reg;
  logic forceEvt_reg;
  logic [1:0] forceAct_reg;

  // real match only on a tick that is not blocked
  assign hit = tick & ~block & (countVal == matchVal);

  // registered so matchEvt lands one clock after the tick, the flag in itc_timer one clock later
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      matchEvt_reg <= 1'b0;
      forceEvt_reg <= 1'b0;
      forceAct_reg <= ITC_ACT_NORMAL;
    end
    else if (ce)
    begin
      matchEvt_reg <= hit;
      forceEvt_reg <= forceReq;
      if (forceReq)
      begin
        forceAct_reg <= action;
      end
    end
  end

  assign matchEvt = matchEvt_reg;
  assign forceEvt = forceEvt_reg;
  assign forceAct = forceAct_reg;
endmodule

/* File: design/itc_pkg.sv */
/*
  constants for the reduced 16-bit timer: register indices, field
  positions, reset values and mode codes.
  assumes byte address = 4 * index on a 32-bit wishbone bus.
*/
package itc_pkg;
  // register indices, byte address is four times these
  localparam int ITC_ADR_W = 12;
  localparam int ITC_IDX_W = 10;
  localparam logic [9:0] ITC_IDX_CTRLA = 10'h120;
  localparam logic [9:0] ITC_IDX_CTRLB = 10'h121;
  localparam logic [9:0] ITC_IDX_FORCE = 10'h122;
  localparam logic [9:0] ITC_IDX_CNTL = 10'h124;
  localparam logic [9:0] ITC_IDX_CNTH = 10'h125;
  localparam logic [9:0] ITC_IDX_CAPL = 10'h126;
  localparam logic [9:0] ITC_IDX_CAPH = 10'h127;
  localparam logic [9:0] ITC_IDX_CMPL = 10'h128;
  localparam logic [9:0] ITC_IDX_FLAG = 10'h12e;
  // channel count and bit layout
  localparam int ITC_NCH = 3;
  localparam int ITC_FORCE_MSB = 7;
  localparam int ITC_ACT_MSB = 7;
  localparam int ITC_MODE_LO_W = 2;
  localparam int ITC_MODE_HI_LSB = 3;
  localparam int ITC_CS_W = 3;
  localparam int ITC_FLAG_OVF = 0;
  localparam int ITC_FLAG_CH0 = 1;
  // reset values
  localparam logic [7:0] ITC_RST8 = 8'h00;
  localparam logic [15:0] ITC_RST16 = 16'h0000;
  localparam logic [31:0] ITC_RST32 = 32'h0000_0000;
  // waveform modes and tops
  localparam logic [3:0] ITC_MODE_NORMAL = 4'h0;
  localparam logic [3:0] ITC_MODE_CTC = 4'h4;
  localparam logic [3:0] ITC_MODE_CTC2 = 4'hc;
  localparam logic [3:0] ITC_MODE_P8A = 4'h1;
  localparam logic [3:0] ITC_MODE_P9A = 4'h2;
  localparam logic [3:0] ITC_MODE_P10A = 4'h3;
  localparam logic [3:0] ITC_MODE_P8B = 4'h5;
  localparam logic [3:0] ITC_MODE_P9B = 4'h6;
  localparam logic [3:0] ITC_MODE_P10B = 4'h7;
  localparam logic [3:0] ITC_MODE_CAPA = 4'h8;
  localparam logic [3:0] ITC_MODE_CAPB = 4'ha;
  localparam logic [3:0] ITC_MODE_CAPC = 4'he;
  localparam logic [3:0] ITC_MODE_RSV = 4'hd;
  localparam logic [15:0] ITC_TOP8 = 16'h00ff;
  localparam logic [15:0] ITC_TOP9 = 16'h01ff;
  localparam logic [15:0] ITC_TOP10 = 16'h03ff;
  localparam logic [15:0] ITC_TOP16 = 16'hffff;
  localparam logic [2:0] ITC_CS_STOP = 3'h0;
  localparam logic [1:0] ITC_ACT_NORMAL = 2'h0;
endpackage

/* File: design/itc_timer.sv */
/*
  reduced 16-bit timer with three compare channels and a capture
  register that never loads, reached over a classic wishbone slave.
  assumes timerTick is a one-clock enable from the shared prescaler,
  on clk, and that flagAck pulses come from the interrupt unit.
*/
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module itc_timer
  import itc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ITC_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic timerTick,
  input wire logic [ITC_NCH:0] flagAck,
  output logic [ITC_CS_W-1:0] clkSel,
  output logic [ITC_NCH:0] flags,
  output logic [ITC_NCH-1:0] forcedMatch,
  output logic [2*ITC_NCH-1:0] forcedAction,
  output logic [15:0] countOut
);
  // pwm test, used by the force gate only
  function automatic logic isPwm(input logic [3:0] m);
    isPwm = !(m == ITC_MODE_NORMAL || m == ITC_MODE_CTC
      || m == ITC_MODE_CTC2 || m == ITC_MODE_RSV);
  endfunction

  // top of count for a mode; pwm modes count up only
  function automatic logic [15:0] topOf(
    input logic [3:0] m,
    input logic [15:0] ocrA,
    input logic [15:0] cap
  );
    case (m)
      ITC_MODE_P8A, ITC_MODE_P8B: topOf = ITC_TOP8;
      ITC_MODE_P9A, ITC_MODE_P9B: topOf = ITC_TOP9;
      ITC_MODE_P10A, ITC_MODE_P10B: topOf = ITC_TOP10;
      ITC_MODE_CAPA, ITC_MODE_CAPB, ITC_MODE_CAPC: topOf = cap;
      ITC_MODE_NORMAL, ITC_MODE_RSV: topOf = ITC_TOP16;
      default: topOf = ocrA;
    endcase
  endfunction

  logic [7:0] ctrlA_reg;
  logic [7:0] ctrlB_reg;
  logic [7:0] temp_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic blockTick_reg;
  logic [ITC_NCH:0] flag_reg;
  logic [ITC_NCH:0] flag_next;
  logic [31:0] rdat_reg;
  logic ack_reg;
  logic [15:0] match_reg [ITC_NCH];
  logic [15:0] capture;
  logic [3:0] mode;
  logic [15:0] top;
  logic tick;
  logic atTop;
  logic access;
  logic takeWr;
  logic takeRd;
  logic lane0;
  logic [ITC_IDX_W-1:0] idx;
  logic [7:0] wByte;
  logic wrCntH;
  logic wrCntL;
  logic wrAnyH;
  logic wrForce;
  logic wrFlag;
  logic [ITC_NCH-1:0] wrCmpL;
  logic [ITC_NCH-1:0] rdCmpL;
  logic rdCntL;
  logic rdCapL;
  logic [ITC_NCH-1:0] forceReq;
  logic [ITC_NCH-1:0] matchEvt;
  logic [ITC_NCH-1:0] forceEvt;
  logic [2*ITC_NCH-1:0] forceAct;
  logic [15:0] rd16;
  logic rdLow;
  logic mapped;
  logic [7:0] rByte;

  // no capture input: the value is a constant
  assign capture = ITC_RST16;

  // mode and clock select fields
  assign mode = {ctrlB_reg[ITC_MODE_HI_LSB+1:ITC_MODE_HI_LSB],
    ctrlA_reg[ITC_MODE_LO_W-1:0]};
  assign clkSel = ctrlB_reg[ITC_CS_W-1:0];
  assign top = topOf(mode, match_reg[0], capture);
  // stopped clock select freezes the count
  assign tick = timerTick & (clkSel != ITC_CS_STOP);
  assign atTop = (count_reg == top);

  // bus decode; write side effects on the edge that sees ack high, read side effects on the edge before
  assign access = cyc_i & stb_i;
  assign takeWr = access & we_i & ack_reg;
  assign takeRd = access & ~we_i & ~ack_reg;
  assign lane0 = sel_i[0];
  assign idx = adr_i[ITC_ADR_W-1:2];
  assign wByte = dat_i[7:0];
  assign wrCntH = takeWr & lane0 & (idx == ITC_IDX_CNTH);
  assign wrCntL = takeWr & lane0 & (idx == ITC_IDX_CNTL);
  assign wrForce = takeWr & lane0 & (idx == ITC_IDX_FORCE);
  assign wrFlag = takeWr & lane0 & (idx == ITC_IDX_FLAG);
  assign rdCntL = takeRd & (idx == ITC_IDX_CNTL);
  assign rdCapL = takeRd & (idx == ITC_IDX_CAPL);

  // per-channel strobes; high bytes of compare values are odd indices
  genvar g;
  generate
    for (g = 0; g < ITC_NCH; g++)
    begin : gch
      localparam logic [ITC_IDX_W-1:0] LO = ITC_IDX_CMPL + ITC_IDX_W'(2 * g);
      assign wrCmpL[g] = takeWr & lane0 & (idx == LO);
      assign rdCmpL[g] = takeRd & (idx == LO);
      // force honoured only outside pwm modes
      assign forceReq[g] = wrForce & wByte[ITC_FORCE_MSB-g] & ~isPwm(mode);
      itc_match_chan #(
        .W(16)
      ) itc_match_chan_inst (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .block(blockTick_reg),
        .forceReq(forceReq[g]),
        .countVal(count_reg),
        .matchVal(match_reg[g]),
        .action(ctrlA_reg[ITC_ACT_MSB-2*g -: 2]),
        .matchEvt(matchEvt[g]),
        .forceEvt(forceEvt[g]),
        .forceAct(forceAct[2*g+1:2*g])
      );
    end
  endgenerate

  // any high byte of a 16-bit register lands only in the shared latch
  assign wrAnyH = takeWr & lane0 & idx[0] & (idx >= ITC_IDX_CNTL)
    & (idx < ITC_IDX_FLAG);

  // counter next value: a bus write beats the tick
  always_comb
  begin
    count_next = count_reg;
    if (wrCntL)
    begin
      count_next = {temp_reg, wByte};
    end
    else if (tick)
    begin
      // forced strobes never reach this clear
      count_next = atTop ? ITC_RST16 : count_reg + 16'h0001;
    end
  end

  // flags: hardware set wins over software or vector clear
  always_comb
  begin
    flag_next = flag_reg;
    if (wrFlag)
    begin
      flag_next = flag_next & ~wByte[ITC_NCH:0];
    end
    flag_next = flag_next & ~flagAck;
    // only real matches set the channel flags, never forced ones
    flag_next[ITC_FLAG_CH0 +: ITC_NCH] = flag_next[ITC_FLAG_CH0 +: ITC_NCH]
      | matchEvt;
    if (tick && count_reg == ITC_TOP16)
    begin
      flag_next[ITC_FLAG_OVF] = 1'b1;
    end
  end

  // read mux: a low byte read returns its own byte, high reads the latch
  assign rdLow = ~idx[0];
  always_comb
  begin
    rd16 = ITC_RST16;
    mapped = 1'b1;
    rByte = ITC_RST8;
    case (idx)
      ITC_IDX_CNTL, ITC_IDX_CNTH: rd16 = count_reg;
      ITC_IDX_CAPL, ITC_IDX_CAPH: rd16 = capture;
      ITC_IDX_CMPL, ITC_IDX_CMPL + 10'h001: rd16 = match_reg[0];
      ITC_IDX_CMPL + 10'h002, ITC_IDX_CMPL + 10'h003: rd16 = match_reg[1];
      ITC_IDX_CMPL + 10'h004, ITC_IDX_CMPL + 10'h005: rd16 = match_reg[2];
      ITC_IDX_CTRLA, ITC_IDX_CTRLB, ITC_IDX_FORCE, ITC_IDX_FLAG: rd16 = ITC_RST16;
      default: mapped = 1'b0;
    endcase
    if (idx == ITC_IDX_CTRLA)
    begin
      rByte = ctrlA_reg;
    end
    else if (idx == ITC_IDX_CTRLB)
    begin
      rByte = ctrlB_reg;
    end
    else if (idx == ITC_IDX_FORCE)
    begin
      rByte = ITC_RST8;
    end
    else if (idx == ITC_IDX_FLAG)
    begin
      rByte = {{(7-ITC_NCH){1'b0}}, flag_reg};
    end
    else if (mapped)
    begin
      rByte = rdLow ? rd16[7:0] : temp_reg;
    end
  end

  // wishbone handshake: ack one clock after the request, dropped after
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_reg <= 1'b0;
      rdat_reg <= ITC_RST32;
    end
    else if (ce)
    begin
      ack_reg <= access & ~ack_reg;
      if (takeRd)
      begin
        rdat_reg <= {24'h000000, rByte};
      end
    end
  end

  // shared latch: filled by high writes and by low reads
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      temp_reg <= ITC_RST8;
    end
    else if (ce)
    begin
      if (wrAnyH)
      begin
        temp_reg <= wByte;
      end
      else if (rdCntL)
      begin
        temp_reg <= count_reg[15:8];
      end
      else if (rdCapL)
      begin
        temp_reg <= capture[15:8];
      end
      else if (|rdCmpL)
      begin
        temp_reg <= rd16[15:8];
      end
    end
  end

  // control registers; both load the whole written byte, action fields included
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrlA_reg <= ITC_RST8;
      ctrlB_reg <= ITC_RST8;
    end
    else if (ce)
    begin
      if (takeWr && lane0 && idx == ITC_IDX_CTRLA)
      begin
        ctrlA_reg <= wByte;
      end
      if (takeWr && lane0 && idx == ITC_IDX_CTRLB)
      begin
        ctrlB_reg <= wByte;
      end
    end
  end

  // counter, its tick block, and flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_reg <= ITC_RST16;
      blockTick_reg <= 1'b0;
      flag_reg <= '0;
    end
    else if (ce)
    begin
      count_reg <= count_next;
      flag_reg <= flag_next;
      // held until the next tick so a slow prescaler cannot miss it
      if (wrCntL)
      begin
        blockTick_reg <= 1'b1;
      end
      else if (tick)
      begin
        blockTick_reg <= 1'b0;
      end
    end
  end

  // compare values load all 16 bits at the low byte write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < ITC_NCH; i++)
      begin
        match_reg[i] <= ITC_RST16;
      end
    end
    else if (ce)
    begin
      for (int i = 0; i < ITC_NCH; i++)
      begin
        if (wrCmpL[i])
        begin
          match_reg[i] <= {temp_reg, wByte};
        end
      end
    end
  end

  // outputs; forced events and their actions leave on forcedMatch and forcedAction
  assign dat_o = rdat_reg;
  assign ack_o = ack_reg;
  assign flags = flag_reg;
  assign forcedMatch = forceEvt;
  assign forcedAction = forceAct;
  assign countOut = count_reg;
endmodule

/* File: testbench/itc_cpu_model.sv */
/*
  processor core model: classic wishbone master with byte and paired
  16-bit accesses through the shared high-byte latch.
  assumes a slave on the same clock that answers with ack.
*/
`timescale 1ns/1ps
module itc_cpu_model
  import itc_pkg::*;
(
  input wire logic clk,
  input wire logic ackI,
  input wire logic [31:0] datI,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [ITC_ADR_W-1:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  // idle bus at time zero
  initial
  begin
    {cyc, stb, we} = 3'b000;
    adr = 12'h000;
    sel = 4'h0;
    dat = 32'h0000_0000;
  end

  // one byte cycle; held until ack is sampled high
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] b,
                      output logic [7:0] q);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    dat <= {24'h000000, b};
    @(posedge clk);
    while (ackI !== 1'b1)
      @(posedge clk);
    q = datI[7:0];
    {cyc, stb, we} <= 3'b000;
    // released lines must not keep showing the old value
    adr <= ~adr;
    sel <= 4'h0;
    dat <= ~dat;
  endtask

  // high byte first so the latch pairs with the low write
  task automatic w16(input logic [9:0] idx, input logic [15:0] v);
    logic [7:0] q;
    xfer(1'b1, idx + 10'h1, v[15:8], q);
    xfer(1'b1, idx, v[7:0], q);
  endtask

  // low byte first: it fills the latch the high read returns
  task automatic rd16(input logic [9:0] idx, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    xfer(1'b0, idx, 8'h00, lo);
    xfer(1'b0, idx + 10'h1, 8'h00, hi);
    v = {hi, lo};
  endtask
endmodule

/* File: testbench/itc_timer_sva.sv */
/*
  port-level checker for the reduced timer.
  assumes no bus traffic while ce is low; bound to itc_timer below.
*/
`timescale 1ns/1ps
module itc_timer_sva
  import itc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ITC_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic timerTick,
  input wire logic [ITC_NCH:0] flags,
  input wire logic [ITC_NCH-1:0] forcedMatch,
  input wire logic [15:0] countOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // decoded bus views
  wire [9:0] idx = adr_i[11:2];
  wire rdAck = ack_o && cyc_i && stb_i && !we_i;
  wire forceWr = cyc_i && stb_i && we_i && ack_o && sel_i[0] && idx == ITC_IDX_FORCE;

  ack_timely_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  force_cause_a: assert property (forcedMatch[2] |-> $past(forceWr && dat_i[5]))
    else $error("forced event without force write");
  force_strobe_a: assert property (forcedMatch[2] |=> !forcedMatch[2])
    else $error("forced event held");
  flag_cause_a: assert property ($rose(flags[3]) |-> $past(timerTick, 2))
    else $error("channel c flag set without tick");
  force_noclear_a: assert property (forcedMatch[2] && !$past(timerTick) |-> $stable(countOut))
    else $error("forced event moved the counter");
  force_readzero_a: assert property (rdAck && idx == ITC_IDX_FORCE |-> dat_o == 32'h0)
    else $error("force register read not zero");
  capture_zero_a: assert property (rdAck && idx == ITC_IDX_CAPL |-> dat_o == 32'h0)
    else $error("capture low byte not zero");
endmodule

bind itc_timer itc_timer_sva itc_timer_sva_inst (
  .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .timerTick(timerTick),
  .flags(flags), .forcedMatch(forcedMatch), .countOut(countOut)
);

/* File: testbench/itc_timer_test.sv */
/*
  self-checking bench for itc_timer: register rows, shared latch,
  force strobes over every mode code but the reserved one, compare blocking and flags.
  assumes the package constants and a 250 MHz clock.
*/
`timescale 1ns/1ps
module itc_timer_test
  import itc_pkg::*;
;
  typedef struct packed {logic [9:0] idx; logic [15:0] wv; logic [15:0] ev;} itc_row_t;
  localparam int LIMIT = 5000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic timerTick = 1'b0;
  logic [3:0] flagAck = 4'h0;
  logic cyc;
  logic stb;
  logic we;
  logic [ITC_ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] datW;
  logic [31:0] datR;
  logic ack;
  logic [2:0] clkSel;
  logic [3:0] flags;
  logic [2:0] forcedMatch;
  logic [5:0] forcedAction;
  logic [15:0] countOut;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  // capture is read-only and unmapped reads give zero
  itc_row_t rows [6] = '{'{ITC_IDX_CMPL, 16'ha55a, 16'ha55a},
    '{ITC_IDX_CMPL + 10'h2, 16'h0ff0, 16'h0ff0}, '{ITC_IDX_CMPL + 10'h4, 16'hc3c3, 16'hc3c3},
    '{ITC_IDX_CNTL, 16'h1234, 16'h1234}, '{ITC_IDX_CAPL, 16'hbeef, 16'h0000},
    '{10'h130, 16'h5a5a, 16'h0000}};

  itc_timer itc_timer_inst (.clk(clk), .rst(rst), .ce(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .timerTick(timerTick), .flagAck(flagAck), .clkSel(clkSel), .flags(flags),
    .forcedMatch(forcedMatch), .forcedAction(forcedAction), .countOut(countOut));
  itc_cpu_model itc_cpu_model_inst (.clk(clk), .ackI(ack), .datI(datR), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(datW));

  initial
    forever #2 clk = ~clk;

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chkVal(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic chkBits(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t got %h want %h", $time, g, e);
    end
  endtask

  // one timer tick, then time for the flag to land
  task automatic tick;
    @(posedge clk);
    timerTick <= 1'b1;
    @(posedge clk);
    timerTick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      summarize();
    end
  end

  initial
  begin
    logic [15:0] v;
    logic [7:0] q;
    logic [3:0] m;
    logic hon;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chkBits({1'b0, clkSel, flags}, 8'h00);
    chkVal(countOut, 16'h0000);
    foreach (rows[i])
    begin
      itc_cpu_model_inst.rd16(rows[i].idx, v);
      chkVal(v, 16'h0000);
    end
    foreach (rows[i])
    begin
      itc_cpu_model_inst.w16(rows[i].idx, rows[i].wv);
      itc_cpu_model_inst.rd16(rows[i].idx, v);
      chkVal(v, rows[i].ev);
    end
    // a lone high write only loads the latch, which any low write uses
    itc_cpu_model_inst.xfer(1'b1, ITC_IDX_CMPL + 10'h1, 8'h77, q);
    itc_cpu_model_inst.xfer(1'b1, ITC_IDX_CMPL + 10'h2, 8'h34, q);
    itc_cpu_model_inst.rd16(ITC_IDX_CMPL, v);
    chkVal(v, 16'ha55a);
    itc_cpu_model_inst.rd16(ITC_IDX_CMPL + 10'h2, v);
    chkVal(v, 16'h7734);
    // force strobes under every mode code but the reserved one
    for (int k = 0; k < 16; k++)
      if (k != 13)
      begin
        m = k[3:0];
        hon = m == ITC_MODE_NORMAL || m == ITC_MODE_CTC || m == ITC_MODE_CTC2;
        itc_cpu_model_inst.xfer(1'b1, ITC_IDX_CTRLA, {4'h0, 2'b10, m[1:0]}, q);
        itc_cpu_model_inst.xfer(1'b1, ITC_IDX_CTRLB, {3'h0, m[3:2], 3'h0}, q);
        itc_cpu_model_inst.xfer(1'b1, ITC_IDX_FORCE, 8'hff, q);
        @(posedge clk);
        chkBits({5'h0, forcedMatch}, hon ? 8'h07 : 8'h00);
        if (hon)
          chkBits({6'h0, forcedAction[5:4]}, 8'h02);
      end
    itc_cpu_model_inst.xfer(1'b0, ITC_IDX_FORCE, 8'h00, q);
    chkBits(q, 8'h00);
    chkBits({4'h0, flags}, 8'h00);
    chkVal(countOut, 16'h1234);
    // counter write blocks the next tick's match on all channels
    itc_cpu_model_inst.xfer(1'b1, ITC_IDX_CTRLA, 8'h00, q);
    itc_cpu_model_inst.xfer(1'b1, ITC_IDX_CTRLB, 8'h01, q);
    for (int k = 0; k < 3; k++)
      itc_cpu_model_inst.w16(ITC_IDX_CMPL + 10'(2 * k), 16'h0041);
    itc_cpu_model_inst.w16(ITC_IDX_CNTL, 16'h0041);
    tick();
    chkBits({4'h0, flags}, 8'h00);
    chkVal(countOut, 16'h0042);
    itc_cpu_model_inst.w16(ITC_IDX_CMPL + 10'h4, 16'h0043);
    tick();
    tick();
    chkBits({4'h0, flags}, 8'h08);
    chkVal(countOut, 16'h0044);
    @(posedge clk);
    flagAck <= 4'h8;
    @(posedge clk);
    flagAck <= 4'h0;
    repeat (2) @(posedge clk);
    chkBits({4'h0, flags}, 8'h00);
    // a low enable must swallow a tick, then counting resumes
    ce <= 1'b0;
    tick();
    chkVal(countOut, 16'h0044);
    ce <= 1'b1;
    tick();
    chkVal(countOut, 16'h0045);
    // mid-run reset clears counter, selects and compare values
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chkBits({1'b0, clkSel, flags}, 8'h00);
    chkVal(countOut, 16'h0000);
    itc_cpu_model_inst.rd16(ITC_IDX_CMPL + 10'h4, v);
    chkVal(v, 16'h0000);
    summarize();
  end
endmodule
